// >>> hw/sscp_config_port.sv
// sscp_config_port: four-wire and two-wire configuration slave with 256 x 8 register space.
// assumes link pins are asynchronous to clock and slow enough (sck, scl) to be oversampled.
// the two-wire lines are open drain with external pull-ups; the bench resolves the wire.
`timescale 1ns/1ps

// Behaviour
// R1: master frames two-wire transactions with start/stop
// R2: nine clocks per byte, ninth is acknowledge
// R3: ack pulls data low; high means not-acknowledge
// R4: write: address, index, data stored at index
// R5: read: index, repeated start, address, data returned
// R6: master not-acknowledges last wanted read byte
// R7: device only pulls lines low or releases
// R8: strap high selects four-wire, else two-wire
// R9: host keeps serial clock at most 20 MHz
// R10: four-wire frame is 17 bits under select
// R11: select high: ignore input, float output
// R12: frame is direction, index, data, msb first
// R13: previous frame shifts out while new shifts in
// R14: output enable follows select low asynchronously
// R15: write frame executes on select rising
// R16: bits captured on serial clock rising edges
// R17: read is two frames, second returns data
// R18: second read frame reads index FF, discarded
// R19: last 17 clocks present index and data
// R20: chained devices each execute on select rising
// R21: host sizes chain by shifting known pattern
// R22: self-clearing internal reset after power-up
// R23: straps give slave address 0D to 1C
// R24: master keeps two-wire clock at most 400 kHz
// R25: output changes on serial clock falling edges
module sscp_config_port
    import sscp_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic mode_sel,
    input wire logic ss_n,
    input wire logic sck_scl,
    input wire logic mosi_sda_in,
    input wire logic [1:0] slave_addr_strap_lo,
    input wire logic [1:0] slave_addr_strap_hi,
    output logic sda_out,
    output logic sda_oe,
    output logic miso,
    output logic miso_oe,
    output logic port_ready,
    output sscp_wr_s cfg_wr
);

    // two-stage synchronisers plus one history stage for edges
    sscp_pins_s pin_raw;
    sscp_pins_s pin_s1;
    sscp_pins_s pin_s2;
    sscp_pins_s pin_s3;

    assign pin_raw = '{mode: mode_sel, ss_n: ss_n, sck: sck_scl, sdi: mosi_sda_in};

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1 <= '{mode: 1'b0, ss_n: 1'b1, sck: 1'b1, sdi: 1'b1};
            pin_s2 <= '{mode: 1'b0, ss_n: 1'b1, sck: 1'b1, sdi: 1'b1};
            pin_s3 <= '{mode: 1'b0, ss_n: 1'b1, sck: 1'b1, sdi: 1'b1};
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // self-clearing power-on reset; straps caught once it ends
    logic [7:0] por_cnt;
    logic por_done;
    logic [6:0] my_addr;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            por_cnt <= 8'h00;
            por_done <= 1'b0;
            my_addr <= SLAVE_ADDR_BASE;
        end else if (!por_done) begin
            por_cnt <= por_cnt + 8'h01; // R22
            if (por_cnt == POR_CNT_MAX) begin
                por_done <= 1'b1; // R22
                my_addr <= SLAVE_ADDR_BASE + {3'b000, slave_addr_strap_lo, slave_addr_strap_hi}; // R23
            end
        end
    end

    // mode decode and pin edges, all from synchronised copies
    wire spi_mode = pin_s2.mode; // R8
    wire spi_act = por_done && spi_mode;
    wire smb_act = por_done && !spi_mode;
    wire sck_rise = pin_s2.sck && !pin_s3.sck;
    wire sck_fall = !pin_s2.sck && pin_s3.sck;
    wire ss_fall = !pin_s2.ss_n && pin_s3.ss_n;
    wire ss_rise = pin_s2.ss_n && !pin_s3.ss_n;
    wire sda_rise = pin_s2.sdi && !pin_s3.sdi;
    wire sda_fall = !pin_s2.sdi && pin_s3.sdi;
    wire smb_start = smb_act && pin_s2.sck && pin_s3.sck && sda_fall; // R1
    wire smb_stop = smb_act && pin_s2.sck && pin_s3.sck && sda_rise; // R1

    // register space
    logic [7:0] regs [REG_COUNT];

    // ---------------- four-wire slave ----------------
    logic [FRAME_BITS-1:0] spi_sr;
    logic [4:0] spi_cnt;

    wire [7:0] spi_idx = spi_sr[FRAME_IDX_MSB:FRAME_IDX_LSB];
    wire spi_is_read = spi_sr[FRAME_DIR_POS];
    // a frame shorter than 17 bits is treated as aborted and not executed
    wire spi_full = (spi_cnt >= FRAME_LEN);
    wire spi_exec = spi_act && ss_rise && spi_full;
    wire spi_we = spi_exec && !spi_is_read;
    wire spi_shift = spi_act && !pin_s2.ss_n && sck_rise;

    // shift register: capture on rising edges, execute at select rising
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            spi_sr <= '0;
            spi_cnt <= 5'h00;
        end else if (spi_act && ss_fall) begin
            spi_cnt <= 5'h00;
        end else if (spi_shift) begin
            spi_sr <= {spi_sr[FRAME_BITS-2:0], pin_s2.sdi}; // R16 R12 R10
            if (!spi_full) begin
                spi_cnt <= spi_cnt + 5'h01;
            end
        end else if (spi_exec && spi_is_read) begin
            // read latches data in place so the next frame shifts it out
            spi_sr[FRAME_DAT_MSB:0] <= regs[spi_idx]; // R17 R18 R19 R20
        end
    end

    // output bit: msb of the shift register, refreshed on falling edges
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            miso <= 1'b0;
        end else if (spi_act && (ss_fall || (!pin_s2.ss_n && sck_fall))) begin
            miso <= spi_sr[FRAME_BITS-1]; // R13 R25
        end
    end

    // enable straight from the select pin; the only path that skips the synchroniser
    assign miso_oe = spi_mode && por_done && !ss_n; // R14 R11

    // ---------------- two-wire slave ----------------
    sscp_smb_state_e smb_state;
    sscp_smb_state_e ack_next;
    logic [3:0] bit_cnt;
    logic [7:0] smb_sh;
    logic [7:0] smb_idx;
    logic smb_we;
    // pulses the cycle after a commit; steps the index for burst writes
    logic smb_adv;

    wire scl_rise = smb_act && sck_rise;
    wire scl_fall = smb_act && sck_fall;
    wire byte_done = (bit_cnt == BYTE_BITS);
    wire [7:0] tx_byte = regs[smb_idx];
    wire [2:0] tx_pos = 3'(4'h7 - bit_cnt);
    wire addr_hit = (smb_sh[7:1] == my_addr); // R23

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            smb_state <= SM_IDLE;
            ack_next <= SM_IDLE;
            bit_cnt <= 4'h0;
            smb_sh <= 8'h00;
            smb_idx <= 8'h00;
            smb_we <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            smb_we <= 1'b0;
            // the commit has already used the old index by now
            if (smb_adv) begin
                smb_idx <= smb_idx + 8'h01; // R4
            end
            if (!smb_act || smb_stop) begin
                smb_state <= SM_IDLE;
                sda_oe <= 1'b0;
            end else if (smb_start) begin
                // start and repeated start both restart the address byte
                smb_state <= SM_ADDR; // R5
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (smb_state)
                    SM_ADDR, SM_INDEX, SM_WDATA: begin
                        smb_sh <= {smb_sh[6:0], pin_s2.sdi};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    SM_RDATA: begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    SM_RACK: begin
                        // high in the slot ends the read
                        if (pin_s2.sdi) begin
                            smb_state <= SM_IDLE; // R3 R6
                        end else begin
                            smb_state <= SM_RDATA;
                            smb_idx <= smb_idx + 8'h01;
                            bit_cnt <= 4'h0;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (smb_state)
                    SM_ADDR: begin
                        if (byte_done && addr_hit) begin
                            sda_oe <= 1'b1; // R3
                            smb_state <= SM_ACK;
                            ack_next <= smb_sh[0] ? SM_RDATA : SM_INDEX; // R4 R5
                        end else if (byte_done) begin
                            smb_state <= SM_IDLE;
                        end
                    end
                    SM_INDEX: begin
                        if (byte_done) begin
                            smb_idx <= smb_sh; // R4
                            sda_oe <= 1'b1;
                            smb_state <= SM_ACK;
                            ack_next <= SM_WDATA;
                        end
                    end
                    SM_WDATA: begin
                        if (byte_done) begin
                            smb_we <= 1'b1; // R4
                            sda_oe <= 1'b1;
                            smb_state <= SM_ACK;
                            ack_next <= SM_WDATA;
                        end
                    end
                    SM_ACK: begin
                        // end of the ninth pulse: release, or drive first read bit
                        bit_cnt <= 4'h0; // R2
                        smb_state <= ack_next;
                        sda_oe <= (ack_next == SM_RDATA) ? !tx_byte[7] : 1'b0; // R5 R7
                    end
                    SM_RDATA: begin
                        if (byte_done) begin
                            sda_oe <= 1'b0; // R2
                            smb_state <= SM_RACK;
                        end else begin
                            sda_oe <= !tx_byte[tx_pos]; // R7
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // two-wire write commits the byte as its acknowledge slot starts, then advances the index
    wire smb_commit = smb_we;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sda_out <= 1'b0; // R7
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ---------------- register space writes ----------------
    sscp_wr_s next_wr;
    assign next_wr = spi_we ? '{we: 1'b1, addr: spi_idx, data: spi_sr[FRAME_DAT_MSB:0]} // R15 R20
                   : '{we: smb_commit, addr: smb_idx, data: smb_sh};

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= REG_RESET;
            end
            cfg_wr <= '0;
        end else begin
            cfg_wr <= next_wr;
            if (next_wr.we) begin
                regs[next_wr.addr] <= next_wr.data;
            end
        end
    end

    // index advance strobe after a two-wire data byte, plus the ready flag
    // the strobe lags the commit by one cycle so the write sees the old index
    // scl edges are many cycles apart, so the step never meets a new index byte
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            smb_adv <= 1'b0;
            port_ready <= 1'b0;
        end else begin
            smb_adv <= smb_commit;
            port_ready <= por_done;
        end
    end

endmodule : sscp_config_port

// >>> inc/sscp_pkg.sv
// sscp_pkg: constants, state codes and carrier types for the serial config port.
// assumes a single 10 MHz system clock; link pins are sampled, not used as clocks.
package sscp_pkg;

    // system clock and self-clearing power-on reset timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int POR_TIME_NS = 2000;
    localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] POR_CNT_MAX = 8'(POR_CYCLES - 1);

    // four-wire frame layout, most significant bit first
    localparam int FRAME_BITS = 17;
    localparam int FRAME_DIR_POS = 16;
    localparam int FRAME_IDX_MSB = 15;
    localparam int FRAME_IDX_LSB = 8;
    localparam int FRAME_DAT_MSB = 7;
    localparam logic [4:0] FRAME_LEN = 5'h11;

    // two-wire slave address: base plus the two strap pairs
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h0D;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // register space and reset contents
    localparam int REG_COUNT = 256;
    localparam logic [7:0] REG_RESET = 8'h00;

    // two-wire slave states
    typedef enum logic [2:0] {
        SM_IDLE = 3'b000,
        SM_ADDR = 3'b001,
        SM_ACK = 3'b010,
        SM_INDEX = 3'b011,
        SM_WDATA = 3'b100,
        SM_RDATA = 3'b101,
        SM_RACK = 3'b110
    } sscp_smb_state_e;

    // one write into the register space
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } sscp_wr_s;

    // synchronised link pins
    typedef struct packed {
        logic mode;
        logic ss_n;
        logic sck;
        logic sdi;
    } sscp_pins_s;

endpackage : sscp_pkg

// >>> verif/sscp_host.sv
// sscp_host: behavioural host master for both serial modes
// assumes one task at a time, called from the bench
`timescale 1ns/1ps
module sscp_host (
    input wire logic clock,
    input wire logic mode_sel,
    input wire logic miso,
    input wire logic sda_oe,
    output logic ss_n,
    output logic sck_scl,
    output logic mosi_sda_in
);
    logic mosi = 1'b0;
    logic sda = 1'b1;
    // open drain wire: device pull wins, else host level or pull-up
    assign mosi_sda_in = mode_sel ? mosi : (sda & ~sda_oe);
    initial ss_n = 1'b1;
    initial sck_scl = 1'b0;
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick
    // sck stands low outside frames; 800 ns per bit
    task automatic spi(input logic [16:0] tx, input int n, output logic [16:0] rx);
        ss_n <= 1'b0;
        rx = '0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi <= tx[i];
            tick(5);
            rx = {rx[15:0], miso};
            sck_scl <= 1'b1;
            tick(3);
            sck_scl <= 1'b0;
        end
        tick(5);
        ss_n <= 1'b1;
        mosi <= ~mosi;
        tick(12);
    endtask : spi
    task automatic smb_bit(input logic b, output logic seen);
        tick(3);
        sda <= b;
        tick(10);
        sck_scl <= 1'b1;
        tick(8);
        seen = mosi_sda_in;
        tick(5);
        sck_scl <= 1'b0;
    endtask : smb_bit
    // start or repeated start, leaving scl low
    task automatic smb_go();
        tick(1);
        sda <= 1'b1;
        tick(4);
        sck_scl <= 1'b1;
        tick(5);
        sda <= 1'b0;
        tick(5);
        sck_scl <= 1'b0;
    endtask : smb_go
    // stop from scl low
    task automatic smb_end();
        tick(1);
        sda <= 1'b0;
        tick(4);
        sck_scl <= 1'b1;
        tick(5);
        sda <= 1'b1;
        tick(5);
    endtask : smb_end
    // address, index, repeated start, address with read, one byte, not-acknowledge
    task automatic smb_read(input logic [23:0] bytes, output logic [7:0] data, output logic [2:0] acks);
        logic s;
        smb_go();
        for (int k = 2; k >= 0; k--) begin
            if (k == 0) smb_go();
            for (int j = 7; j >= 0; j--) smb_bit(bytes[8 * k + j], s);
            smb_bit(1'b1, s);
            acks[k] = ~s;
        end
        for (int j = 7; j >= 0; j--) begin
            smb_bit(1'b1, s);
            data[j] = s;
        end
        smb_bit(1'b1, s);
        smb_end();
    endtask : smb_read
    // start, three bytes with ack slots, stop
    task automatic smb_write(input logic [23:0] bytes, output logic [2:0] acks);
        logic s;
        sck_scl <= 1'b1;
        tick(5);
        sda <= 1'b0;
        tick(5);
        sck_scl <= 1'b0;
        for (int k = 2; k >= 0; k--) begin
            for (int j = 7; j >= 0; j--) smb_bit(bytes[8 * k + j], s);
            smb_bit(1'b1, s);
            acks[k] = ~s;
        end
        tick(1);
        sda <= 1'b0;
        tick(4);
        sck_scl <= 1'b1;
        tick(5);
        sda <= 1'b1;
        tick(5);
    endtask : smb_write
endmodule : sscp_host

// >>> verif/sscp_props_properties.sv
// sscp_props: port-level checks of the serial config port
// assumes a bind onto sscp_config_port, one clock domain
`timescale 1ns/1ps
module sscp_props
    import sscp_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic mode_sel,
    input wire logic ss_n,
    input wire logic sck_scl,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic port_ready,
    input wire sscp_wr_s cfg_wr
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // open drain data and select gating of the output
    pull_only_a: assert property (sda_out == 1'b0) else $error("sda driven high");
    float_idle_a: assert property (ss_n |-> !miso_oe) else $error("miso on while idle");
    enable_sel_a: assert property ((mode_sel && port_ready)[*3] ##0 !ss_n |-> miso_oe) else $error("miso off");
    spi_only_a: assert property ((!mode_sel)[*4] |-> !miso_oe) else $error("miso in two-wire");
    smb_only_a: assert property (mode_sel[*4] |-> !sda_oe) else $error("sda pulled in four-wire");
    // four-wire writes land after select rises; every write lasts one cycle
    write_late_a: assert property (cfg_wr.we && mode_sel |-> ss_n && $past(ss_n, 2)) else $error("early write");
    write_pulse_a: assert property (cfg_wr.we |=> !cfg_wr.we) else $error("long write");
    // sync lag is 3 cycles, so sck was low when the fall was seen
    miso_fall_a: assert property ($changed(miso) && !ss_n |-> !$past(sck_scl, 3)) else $error("miso moved");
endmodule : sscp_props

// >>> verif/test_sscp_config_port.sv
// test_sscp_config_port: self-checking bench for the config port
// assumes sscp_host as the far side; straps give address 13h
`timescale 1ns/1ps
module test_sscp_config_port;
    import sscp_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic mode_sel = 1'b1;
    logic ss_n, sck_scl, mosi_sda_in, sda_out, sda_oe, miso, miso_oe, port_ready;
    sscp_wr_s cfg_wr;
    sscp_wr_s last_wr = '0;
    int n_wr = 0;
    int n_errors = 0;
    int num_checks = 0;
    logic [16:0] rx;
    logic [2:0] acks;
    logic [7:0] rd;
    always #50 clock = ~clock;
    sscp_config_port i_sscp_config_port (.clock(clock), .sys_rst(sys_rst), .mode_sel(mode_sel), .ss_n(ss_n),
        .sck_scl(sck_scl), .mosi_sda_in(mosi_sda_in), .slave_addr_strap_lo(2'h1), .slave_addr_strap_hi(2'h2),
        .sda_out(sda_out), .sda_oe(sda_oe), .miso(miso), .miso_oe(miso_oe), .port_ready(port_ready),
        .cfg_wr(cfg_wr));
    sscp_host i_sscp_host (.clock(clock), .mode_sel(mode_sel), .miso(miso), .sda_oe(sda_oe), .ss_n(ss_n),
        .sck_scl(sck_scl), .mosi_sda_in(mosi_sda_in));
    // keep the last register write seen
    always @(posedge clock) begin
        if (cfg_wr.we === 1'b1) begin
            last_wr <= cfg_wr;
            n_wr <= n_wr + 1;
        end
    end
    task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // write, then a two-frame read of the same index, then a short frame
    task automatic spi_test();
        int n0;
        i_sscp_host.spi({1'b0, 8'h34, 8'h3C}, 17, rx);
        check("spi write", {1'b1, 8'h34, 8'h3C}, last_wr);
        n0 = n_wr;
        i_sscp_host.spi({1'b1, 8'h34, 8'hFF}, 17, rx);
        check("echo", {1'b0, 8'h34, 8'h3C}, rx);
        i_sscp_host.spi({1'b1, 8'hFF, 8'hFF}, 17, rx);
        check("read", {1'b1, 8'h34, 8'h3C}, rx);
        i_sscp_host.spi({1'b0, 8'h56, 8'h77}, 10, rx);
        check("short frame", 17'(n0), 17'(n_wr));
    endtask : spi_test
    // wrong address goes unanswered, right one stores the byte
    task automatic smb_test();
        mode_sel <= 1'b0;
        i_sscp_host.tick(10);
        i_sscp_host.smb_write({8'h28, 8'h40, 8'hA5}, acks);
        check("nack", 17'h0, {14'h0, acks});
        i_sscp_host.smb_write({8'h26, 8'h40, 8'hA5}, acks);
        check("ack", 17'h7, {14'h0, acks});
        check("smb write", {1'b1, 8'h40, 8'hA5}, last_wr);
        i_sscp_host.smb_read({8'h26, 8'h40, 8'h27}, rd, acks);
        check("read acks", 17'h7, {14'h0, acks});
        check("smb read", {9'h0, 8'hA5}, {9'h0, rd});
    endtask : smb_test
    task automatic give_verdict();
        if (n_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (30) @(posedge clock);
        check("ready", 17'h1, {16'h0, port_ready});
        spi_test();
        smb_test();
        give_verdict();
    end
    // run needs about 3050 cycles
    initial begin
        #1000000;
        n_errors++;
        give_verdict();
    end
endmodule : test_sscp_config_port
bind sscp_config_port sscp_props i_sscp_props (.clock(clock), .sys_rst(sys_rst), .mode_sel(mode_sel), .ss_n(ss_n),
    .sck_scl(sck_scl), .sda_out(sda_out), .sda_oe(sda_oe), .miso(miso), .miso_oe(miso_oe),
    .port_ready(port_ready), .cfg_wr(cfg_wr));
